/* File: shared/acs_defs.svh */
// Constants for the converter sequencer: offsets, fields, resets, timing.
// Assumes a 250 MHz clock and a 32-bit AHB-Lite register bus.
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH
`define ACS_OFF_CTRL 8'h00
`define ACS_OFF_DELAY 8'h04
`define ACS_OFF_STATUS 8'h08
`define ACS_OFF_SINGLE 8'h0C
`define ACS_OFF_REPEAT 8'h10
`define ACS_OFF_READ0 8'h14
`define ACS_OFF_IRQ_MASK 8'h60
`define ACS_READ_LAST 8'h50
`define ACS_BIT_ENABLE 0
`define ACS_BIT_ONESHOT 1
`define ACS_BIT_PERIODIC 2
`define ACS_BIT_INHIBIT 3
`define ACS_BIT_SOFTRST 4
`define ACS_BIT_RPT_DONE 6
`define ACS_BIT_SGL_DONE 7
`define ACS_NCH 16
`define ACS_RES_W 12
`define ACS_TICK_NS 40000
`define ACS_CLK_NS 4
`define ACS_TICK_CYC (`ACS_TICK_NS / `ACS_CLK_NS)
`define ACS_TICK_W 14
`define ACS_ZERO32 32'h0000_0000
`define ACS_ZERO16 16'h0000
`endif

/* File: shared/acs_pkg.sv */
// Types for the converter sequencer; no constants beyond widths in types.
// Assumes acs_defs.svh is visible on the include path.
`default_nettype none
`include "acs_defs.svh"
package acs_pkg;
    typedef enum logic [2:0] {
        ACS_IDLE, ACS_WAIT, ACS_CONV, ACS_NEXT, ACS_DONE
    } acs_state_t;
    // Handshake to the analog converter core.
    typedef struct packed {
        logic core_en;
        logic core_rst;
        logic conv_start;
        logic [3:0] conv_chan;
    } acs_core_req_t;
    typedef struct packed {
        logic conv_done;
        logic [`ACS_RES_W-1:0] conv_result;
    } acs_core_rsp_t;
endpackage
`default_nettype wire

/* File: src/acs_sequencer.sv */
// Conversion sequencer with AHB-Lite register slave and core control.
// Assumes one analog core that pulses conv_done after each conv_start.
`timescale 1ns/1ps
`default_nettype none
`include "acs_defs.svh"
module acs_sequencer (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire acs_pkg::acs_core_rsp_t core_rsp,
    output acs_pkg::acs_core_req_t core_req,
    output logic irq
);
    // Entire state of the block in one packed struct.
    typedef struct packed {
        logic enable;
        logic oneshot;
        logic periodic;
        logic inhibit;
        logic softrst;
        logic sgl_done;
        logic rpt_done;
        logic [31:0] delay;
        logic [15:0] ch_flags;
        logic [15:0] sgl_mask;
        logic [15:0] rpt_mask;
        logic [7:0] irq_mask;
        logic [`ACS_NCH-1:0][`ACS_RES_W-1:0] result;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic [`ACS_TICK_W-1:0] presc;
        logic [15:0] dcnt;
        logic first;
        logic cyc_rpt;
        logic [15:0] cyc_mask;
        logic [3:0] chan;
        acs_pkg::acs_state_t st;
        acs_pkg::acs_core_req_t req;
        logic irq;
        logic hrdy;
        logic hresp;
    } acs_regs_t;

    acs_regs_t r_ff;
    acs_regs_t nxt_r;
    logic tick;
    logic rd_req;
    logic [15:0] ch_set;
    logic [31:0] rd_val;
    logic [7:0] irq_stat;
    logic [7:0] rd_idx;

    // Every check in this module runs on the bus clock and is held off
    // while the system reset is low, so one default serves them all.
    default clocking acs_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // The divider free-runs from reset, so the first tick of a delay comes
    // anywhere within one step; a delay may run short by under one step.
    assign tick = (r_ff.presc == `ACS_TICK_W'(`ACS_TICK_CYC - 1));
    assign rd_req = hsel && hready && htrans[1] && !hwrite;
    assign irq_stat = {r_ff.sgl_done, r_ff.rpt_done, 6'h00};
    assign rd_idx = (haddr - `ACS_OFF_READ0) >> 2;

    // One flag per channel: a finishing conversion sets it.
    for (genvar g = 0; g < `ACS_NCH; g++) begin : g_set
        assign ch_set[g] = core_rsp.conv_done && r_ff.st == acs_pkg::ACS_CONV
            && r_ff.chan == 4'(g);
    end

    // Read mux; reading registers return zero above the result.
    always_comb begin
        rd_val = `ACS_ZERO32;
        if (haddr >= `ACS_OFF_READ0 && haddr <= `ACS_READ_LAST
            && haddr[1:0] == 2'h0) begin
            rd_val = {20'h00000, r_ff.result[rd_idx[3:0]]};
        end else begin
            case (haddr)
                `ACS_OFF_CTRL: rd_val = {24'h000000, r_ff.sgl_done,
                    r_ff.rpt_done, 1'b0, r_ff.softrst, r_ff.inhibit,
                    r_ff.periodic, r_ff.oneshot, r_ff.enable};
                `ACS_OFF_DELAY: rd_val = r_ff.delay;
                `ACS_OFF_STATUS: rd_val = {16'h0000, r_ff.ch_flags};
                `ACS_OFF_SINGLE: rd_val = {16'h0000, r_ff.sgl_mask};
                `ACS_OFF_REPEAT: rd_val = {16'h0000, r_ff.rpt_mask};
                `ACS_OFF_IRQ_MASK: rd_val = {24'h000000, r_ff.irq_mask};
                default: rd_val = `ACS_ZERO32;
            endcase
        end
    end

    // Next-state logic for bus, flags and the sequencing machine.
    always_comb begin
        logic wr;
        logic [31:0] d;
        logic [15:0] first_ch;
        logic found;
        nxt_r = r_ff;
        wr = r_ff.wr_pend;
        d = hwdata;
        first_ch = `ACS_ZERO16;
        found = 1'b0;
        // Writes land at the end of their data phase. A read whose address
        // phase overlaps that data phase would see the old value; a master
        // that idles through each data phase never meets this.
        nxt_r.wr_pend = hsel && hready && htrans[1] && hwrite;
        if (hsel && hready && htrans[1]) begin
            nxt_r.wr_addr = haddr;
        end
        if (rd_req) begin
            nxt_r.rdata = rd_val;
        end
        nxt_r.presc = tick ? `ACS_TICK_W'(0) : r_ff.presc + 1'b1;
        // Zero wait states and an OKAY answer, both straight from flops.
        nxt_r.hrdy = 1'b1;
        nxt_r.hresp = 1'b0;
        nxt_r.req.core_rst = r_ff.softrst;
        nxt_r.req.conv_start = 1'b0;
        // Sticky flags: set after clear so a coincident event survives.
        if (wr) begin
            case (r_ff.wr_addr)
                `ACS_OFF_CTRL: begin
                    nxt_r.enable = d[`ACS_BIT_ENABLE];
                    nxt_r.oneshot = d[`ACS_BIT_ONESHOT];
                    nxt_r.periodic = d[`ACS_BIT_PERIODIC];
                    nxt_r.inhibit = d[`ACS_BIT_INHIBIT];
                    nxt_r.softrst = d[`ACS_BIT_SOFTRST];
                    if (d[`ACS_BIT_SGL_DONE]) nxt_r.sgl_done = 1'b0;
                    if (d[`ACS_BIT_RPT_DONE]) nxt_r.rpt_done = 1'b0;
                    if (d[`ACS_BIT_ENABLE] && !r_ff.enable) begin
                        nxt_r.req.core_rst = 1'b1;
                    end
                    if (d[`ACS_BIT_PERIODIC] && !r_ff.periodic) begin
                        nxt_r.first = 1'b1;
                    end
                end
                `ACS_OFF_DELAY: nxt_r.delay = d;
                `ACS_OFF_STATUS: nxt_r.ch_flags = r_ff.ch_flags & ~d[15:0];
                `ACS_OFF_SINGLE: nxt_r.sgl_mask = d[15:0];
                `ACS_OFF_REPEAT: nxt_r.rpt_mask = d[15:0];
                `ACS_OFF_IRQ_MASK: nxt_r.irq_mask = d[7:0];
                default: ;
            endcase
        end
        nxt_r.ch_flags = nxt_r.ch_flags | ch_set;
        // Clearing the periodic bit also empties the interval timer.
        if (!nxt_r.periodic) begin
            nxt_r.dcnt = `ACS_ZERO16;
        end
        // Channel stepping: pick the lowest selected channel left.
        // Lowest first keeps the order fixed whatever the mask holds.
        for (int i = `ACS_NCH - 1; i >= 0; i--) begin
            if (r_ff.cyc_mask[i]) begin
                first_ch = 16'(i);
                found = 1'b1;
            end
        end
        case (r_ff.st)
            acs_pkg::ACS_IDLE: begin
                nxt_r.req.core_en = r_ff.inhibit && r_ff.enable;
                if (r_ff.softrst || !r_ff.enable) begin
                    nxt_r.req.core_en = 1'b0;
                end else if (r_ff.oneshot) begin
                    nxt_r.oneshot = 1'b0;
                    nxt_r.cyc_mask = r_ff.sgl_mask;
                    nxt_r.cyc_rpt = 1'b0;
                    nxt_r.req.core_en = 1'b1;
                    nxt_r.st = acs_pkg::ACS_NEXT;
                end else if (r_ff.periodic) begin
                    // The start delay applies once after arming.
                    nxt_r.dcnt = r_ff.first ? r_ff.delay[15:0]
                        : r_ff.delay[31:16];
                    nxt_r.first = 1'b0;
                    nxt_r.st = acs_pkg::ACS_WAIT;
                end
            end
            acs_pkg::ACS_WAIT: begin
                // Power follows the inhibit bit while waiting, so that a late
                // switch to power saving still drops the core.
                nxt_r.req.core_en = r_ff.inhibit && r_ff.enable;
                if (!r_ff.periodic || !r_ff.enable) begin
                    nxt_r.st = acs_pkg::ACS_IDLE;
                end else if (r_ff.dcnt != `ACS_ZERO16) begin
                    // Each tick takes 40 us off; full scale is about 2.6 s.
                    if (tick) begin
                        nxt_r.dcnt = r_ff.dcnt - 1'b1;
                    end
                end else if (!r_ff.softrst) begin
                    // A core held in soft reset would never answer, so the
                    // cycle waits for its release.
                    nxt_r.cyc_mask = r_ff.rpt_mask;
                    nxt_r.cyc_rpt = 1'b1;
                    nxt_r.req.core_en = 1'b1;
                    nxt_r.st = acs_pkg::ACS_NEXT;
                end
            end
            acs_pkg::ACS_NEXT: begin
                if (found) begin
                    nxt_r.chan = first_ch[3:0];
                    nxt_r.cyc_mask[first_ch[3:0]] = 1'b0;
                    nxt_r.req.conv_chan = first_ch[3:0];
                    nxt_r.req.conv_start = 1'b1;
                    nxt_r.st = acs_pkg::ACS_CONV;
                end else begin
                    nxt_r.st = acs_pkg::ACS_DONE;
                end
            end
            acs_pkg::ACS_CONV: begin
                // Runs to the end even if enable or periodic drop.
                if (core_rsp.conv_done) begin
                    nxt_r.result[r_ff.chan] = core_rsp.conv_result;
                    nxt_r.st = acs_pkg::ACS_NEXT;
                end else if (r_ff.softrst) begin
                    // A core put into soft reset drops its conversion, so
                    // the cycle is abandoned without a done flag.
                    nxt_r.st = acs_pkg::ACS_IDLE;
                end
            end
            acs_pkg::ACS_DONE: begin
                // Set comes after any clear above, so a coincident one loses.
                if (r_ff.cyc_rpt) nxt_r.rpt_done = 1'b1;
                else nxt_r.sgl_done = 1'b1;
                nxt_r.req.core_en = r_ff.inhibit && r_ff.enable;
                nxt_r.st = acs_pkg::ACS_IDLE;
            end
            default: nxt_r.st = acs_pkg::ACS_IDLE;
        endcase
        // Built from the next flags, so the registered level has no lag.
        nxt_r.irq = |({nxt_r.sgl_done, nxt_r.rpt_done, 6'h00}
            & nxt_r.irq_mask);
    end

    // Single register stage for the whole block.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // Every output is taken straight from the state register.
    assign hrdata = r_ff.rdata;
    assign hreadyout = r_ff.hrdy;
    assign hresp = r_ff.hresp;
    assign core_req = r_ff.req;
    assign irq = r_ff.irq;

    // Checks beside the logic they guard, on the default clock and reset.
    AST_ONESHOT_CLEARS: assert property (
        r_ff.oneshot && r_ff.enable && !r_ff.softrst
        && r_ff.st == acs_pkg::ACS_IDLE |=> !r_ff.oneshot)
        else $error("one-shot bit did not self clear");
    AST_SOFTRST_HOLD: assert property (
        r_ff.softrst |=> core_req.core_rst)
        else $error("core not held in reset");
    AST_SOFTRST_FREE: assert property (
        !r_ff.softrst && !r_ff.wr_pend |=> !core_req.core_rst)
        else $error("core held in reset after release");
    AST_NO_START_DISABLED: assert property (
        r_ff.st == acs_pkg::ACS_IDLE && !r_ff.enable
        |=> r_ff.st != acs_pkg::ACS_NEXT)
        else $error("cycle started while disabled");
    AST_ENABLE_RST: assert property (
        $rose(r_ff.enable) |-> core_req.core_rst)
        else $error("no reset pulse on enable rise");
    AST_DONE_FLAG: assert property (
        r_ff.st == acs_pkg::ACS_DONE && !r_ff.cyc_rpt |=> r_ff.sgl_done)
        else $error("single done flag not set");
    AST_TIMER_CLEAR: assert property (
        !r_ff.periodic |=> r_ff.dcnt == `ACS_ZERO16)
        else $error("interval timer not cleared");
    AST_WAIT_GATES_EN: assert property (
        r_ff.st == acs_pkg::ACS_WAIT && !r_ff.inhibit
        && r_ff.dcnt != `ACS_ZERO16 |=> !core_req.core_en)
        else $error("core enabled before delay elapsed");
    AST_TICK_PERIOD: assert property (
        tick |=> !tick [*8])
        else $error("tick period too short");
    AST_FLAG_SET: assert property (
        ch_set[0] |=> r_ff.ch_flags[0])
        else $error("channel flag not set");
    AST_IRQ_LEVEL: assert property (
        irq == |(irq_stat & r_ff.irq_mask))
        else $error("interrupt level disagrees with flags");
    AST_ONESHOT_NOW: assert property (
        r_ff.st == acs_pkg::ACS_IDLE && r_ff.oneshot && r_ff.enable
        && !r_ff.softrst |=> r_ff.st == acs_pkg::ACS_NEXT)
        else $error("one-shot cycle did not start at once");
    AST_PERIODIC_ARMS: assert property (
        r_ff.st == acs_pkg::ACS_IDLE && r_ff.periodic && !r_ff.oneshot
        && r_ff.enable && !r_ff.softrst |=> r_ff.st == acs_pkg::ACS_WAIT)
        else $error("periodic run did not arm its timer");
    AST_DISABLE_OFF: assert property (
        r_ff.st == acs_pkg::ACS_DONE && !r_ff.enable |=> !core_req.core_en)
        else $error("core left powered after disable");
    AST_REPEAT_STOP: assert property (
        r_ff.st == acs_pkg::ACS_WAIT && !r_ff.periodic
        |=> r_ff.st == acs_pkg::ACS_IDLE)
        else $error("periodic cycle not blocked");
    COV_ONESHOT: cover property (
        r_ff.st == acs_pkg::ACS_DONE && !r_ff.cyc_rpt);
    COV_REPEAT: cover property (
        r_ff.st == acs_pkg::ACS_DONE && r_ff.cyc_rpt);
    COV_WAIT_TICK: cover property (
        r_ff.st == acs_pkg::ACS_WAIT && tick);
    COV_SOFT_RESET: cover property (
        r_ff.softrst && core_req.core_rst);
    COV_ENABLE_RISE: cover property (
        $rose(r_ff.enable));
endmodule
`default_nettype wire

/* File: bench/acs_core_model.sv */
// Behavioural model of the analog converter core facing the sequencer.
// Assumes one conv_start pulse per channel; answers LAT cycles later.
`timescale 1ns/1ps
`default_nettype none
module acs_core_model #(parameter int LAT = 3) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire acs_pkg::acs_core_req_t core_req,
    output acs_pkg::acs_core_rsp_t core_rsp
);
    int cnt;
    logic [3:0] chan;
    // The result names its channel, and it inverts every cycle between answers
    // so that a sample taken one cycle off can never pass for a fresh one.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 0;
            chan <= 4'h0;
            core_rsp <= '0;
        end else begin
            core_rsp.conv_done <= 1'b0;
            core_rsp.conv_result <= ~core_rsp.conv_result;
            if (core_req.conv_start && !core_req.core_rst) begin
                cnt <= LAT;
                chan <= core_req.conv_chan;
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end else if (cnt == 1) begin
                cnt <= 0;
                core_rsp.conv_done <= 1'b1;
                core_rsp.conv_result <= {8'hA0, chan};
            end
        end
    end
endmodule
`default_nettype wire

/* File: bench/adc_conversion_sequencer_bench.sv */
// Self-checking bench: AHB-Lite register accesses against the sequencer.
// Assumes acs_defs.svh on the include path and the core model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "acs_defs.svh"
module adc_conversion_sequencer_bench;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata, q;
    logic hready, hresp, irq;
    acs_pkg::acs_core_rsp_t core_rsp;
    acs_pkg::acs_core_req_t core_req;
    int num_errors = 0, checks = 0, starts = 0, rsts = 0, n, s0;
    logic rst_q = 1'b0;
    acs_sequencer acs_sequencer_inst (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .core_rsp(core_rsp),
        .core_req(core_req), .irq(irq));
    acs_core_model acs_core_model_inst (.hclk(hclk), .hresetn(hresetn),
        .core_req(core_req), .core_rsp(core_rsp));
    // Clock at 250 MHz.
    initial begin
        forever #2 hclk = ~hclk;
    end
    // Count core starts and core reset pulses as the core would see them.
    always @(posedge hclk) begin
        rst_q <= core_req.core_rst;
        if (core_req.conv_start === 1'b1) starts <= starts + 1;
        if (core_req.core_rst === 1'b1 && rst_q === 1'b0) rsts <= rsts + 1;
    end
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // Waits for hready at a rising edge; a hang ends the run as a failure.
    task automatic wait_rdy();
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hready !== 1'b1 && k < 50);
        if (hready !== 1'b1) begin
            num_errors++;
            print_verdict();
        end
    endtask
    // One single word transfer; entered just after a rising edge.
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        bus(a, 1'b0, 32'h0, r);
    endtask
    // Polls the control register until the given done bit is set.
    task automatic wait_done(input int b);
        n = 0;
        do begin
            rd(`ACS_OFF_CTRL, q);
            n++;
        end while (q[b] !== 1'b1 && n < 9000);
        if (n >= 9000) begin
            num_errors++;
            print_verdict();
        end
    endtask
    // Main sequence; each access follows the previous data phase directly.
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(`ACS_OFF_CTRL, q); check(q, 32'h0);
        rd(`ACS_OFF_DELAY, q); check(q, 32'h0);
        rd(8'h70, q); check(q, 32'h0);
        check(hresp, 1'b0);
        wr(`ACS_OFF_DELAY, 32'hFFFF_FFFF);
        rd(`ACS_OFF_DELAY, q); check(q, 32'hFFFF_FFFF);
        wr(`ACS_OFF_DELAY, 32'h0000_0001);
        wr(`ACS_OFF_SINGLE, 32'h0000_8005);
        // A one-shot while disabled must not reach the core.
        wr(`ACS_OFF_CTRL, 32'h02);
        repeat (100) @(posedge hclk);
        check(starts, 0);
        s0 = rsts;
        wr(`ACS_OFF_CTRL, 32'h01);
        repeat (4) @(posedge hclk);
        check(rsts, s0 + 1);
        wr(`ACS_OFF_IRQ_MASK, 32'h80);
        wr(`ACS_OFF_CTRL, 32'h03);
        wait_done(`ACS_BIT_SGL_DONE);
        check(n < 100, 1'b1);
        check(q, 32'h81);
        check(starts, 3);
        rd(`ACS_OFF_STATUS, q); check(q, 32'h8005);
        rd(`ACS_READ_LAST, q); check(q, 32'hA0F);
        check(irq, 1'b1);
        wr(`ACS_OFF_STATUS, 32'h1);
        rd(`ACS_OFF_STATUS, q); check(q, 32'h8004);
        wr(`ACS_OFF_CTRL, 32'h01);
        rd(`ACS_OFF_CTRL, q); check(q, 32'h81);
        wr(`ACS_OFF_CTRL, 32'h81);
        rd(`ACS_OFF_CTRL, q); check(q, 32'h01);
        check(irq, 1'b0);
        // Periodic run: one tick of start delay, core held off meanwhile.
        wr(`ACS_OFF_REPEAT, 32'h2);
        s0 = starts;
        wr(`ACS_OFF_CTRL, 32'h05);
        repeat (20) @(posedge hclk);
        check(starts, s0);
        check(core_req.core_en, 1'b0);
        wait_done(`ACS_BIT_RPT_DONE);
        check(starts > s0, 1'b1);
        wr(`ACS_OFF_CTRL, 32'h41);
        repeat (60) @(posedge hclk);
        s0 = starts;
        repeat (300) @(posedge hclk);
        check(starts, s0);
        // Power saving off keeps the core powered while enabled.
        wr(`ACS_OFF_CTRL, 32'h09);
        repeat (8) @(posedge hclk);
        check(core_req.core_en, 1'b1);
        wr(`ACS_OFF_CTRL, 32'h19);
        repeat (4) @(posedge hclk);
        check(core_req.core_rst, 1'b1);
        rd(`ACS_OFF_DELAY, q); check(q, 32'h1);
        wr(`ACS_OFF_CTRL, 32'h09);
        repeat (4) @(posedge hclk);
        check(core_req.core_rst, 1'b0);
        wr(`ACS_OFF_CTRL, 32'h00);
        repeat (20) @(posedge hclk);
        check(core_req.core_en, 1'b0);
        print_verdict();
    end
endmodule
`default_nettype wire
